/* src/ctw_chain.sv */
`timescale 1ns/10ps
// Prescaler plus fifteen-stage counter chain
module ctw_chain
  import ctw_pkg::*;
(
  // Clocking
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Control
  input wire logic clear,
  // State
  output logic [CTW_CHAIN_W-1:0] chain_q,
  output logic tick
);
  logic [1:0] pre_q;

  assign tick = clk_en && !clear && (pre_q == CTW_PRESCALE_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 2'h0;
      chain_q <= '0;
    end else if (clk_en) begin
      if (clear) begin
        pre_q <= 2'h0;
        chain_q <= '0;
      end else begin
        pre_q <= pre_q + 2'h1;
        if (tick) begin
          chain_q <= chain_q + 15'h1;
        end
      end
    end
  end
endmodule

/* src/ctw_pkg.sv */
// Summary of operation
// - Rate select 00..11 gives periodic period of 2^15..2^18 oscillator cycles.
// - Watchdog times out after seven to eight selected periodic periods.
// - Fifteen-stage counter fed by a divide-by-eight oscillator prescaler.
// - Low eight counter stages readable any time; writes ignored.
// - Power-on clears chain, startup delay 16 or 4064 bus cycles, clear again.
// - Count register advances every eight oscillator cycles, four bus cycles.
// - Overflow event at eighth stage every 2048 oscillator cycles.
// - Watchdog is four extra stages, active only with enable option.
// - Enabled watchdog timing out uncleared resets the device.
// - Writing 0 to the watchdog clear bit clears the watchdog stages.
// - Enabled watchdog keeps counting in run, wait and halt.
// - Stop clears the watchdog and removes its clock during stop.
// - Stop-to-halt option runs stop as halt, watchdog keeps running.
// - High-voltage detect on programming pin turns the watchdog off.
// - Write-only security bit, once set, protects program memory 0700-1fff.
// - Optional-features bit enables comparator port drive and capacitor offset.
// - Overflow flag sets on low-stage rollover ff to 00, interrupts if enabled.
// - Periodic flag sets on selected periodic output, interrupts if enabled.
// - Writing 1 to a flag-clear bit clears its flag; clear bits read 0.
// - Reset sets both rate select bits, longest period and timeout.
package ctw_pkg;
  // Byte addresses on the bus
  localparam logic [3:0] CTW_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CTW_ADDR_COUNT = 4'h4;
  localparam logic [3:0] CTW_ADDR_WDOG = 4'h8;
  // Control register fields
  localparam int CTW_B_OVF_FLAG = 7;
  localparam int CTW_B_PER_FLAG = 6;
  localparam int CTW_B_OVF_IE = 5;
  localparam int CTW_B_PER_IE = 4;
  localparam int CTW_B_OVF_CLR = 3;
  localparam int CTW_B_PER_CLR = 2;
  localparam int CTW_B_SEL_HI = 1;
  localparam int CTW_B_SEL_LO = 0;
  // Watchdog and security fields
  localparam int CTW_B_PROTECT = 2;
  localparam int CTW_B_OPTFEAT = 1;
  localparam int CTW_B_WD_CLR = 0;
  localparam logic [1:0] CTW_SEL_RESET = 2'h3;
  // Bus cycles per count; the oscillator runs at twice the bus rate
  localparam int CTW_PRESCALE_BUS = 4;
  localparam logic [1:0] CTW_PRESCALE_LAST = 2'(CTW_PRESCALE_BUS - 1);
  localparam int CTW_CHAIN_W = 15;
  localparam int CTW_WD_W = 4;
  localparam logic [3:0] CTW_WD_TIMEOUT = 4'h7;
  localparam int CTW_DELAY_SHORT = 16;
  localparam int CTW_DELAY_LONG = 4064;
  localparam logic [12:0] CTW_DELAY_SHORT_C = 13'(CTW_DELAY_SHORT);

  typedef struct packed {
    logic wait_mode;
    logic halt_mode;
    logic stop_mode;
  } ctw_mode_t;

  typedef struct packed {
    logic wd_enable;
    logic stop_to_halt;
    logic long_delay;
  } ctw_option_t;
endpackage

/* src/ctw_top.sv */
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module ctw_top
  import ctw_pkg::*;
#(
  parameter int DELAY_LONG = CTW_DELAY_LONG
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device status and mask options
  input wire ctw_mode_t mode,
  input wire ctw_option_t options,
  input wire logic prog_voltage_high,
  // Results
  output logic overflow_irq,
  output logic periodic_irq,
  output logic system_reset_req,
  output logic in_startup,
  output logic program_memory_protect,
  output logic optional_features_enable
);
  localparam logic [12:0] DELAY_LONG_C = 13'(DELAY_LONG);

  logic [CTW_CHAIN_W-1:0] chain;
  logic tick;
  logic chain_clear;
  logic [12:0] start_cnt_q;
  logic startup_q;
  logic [12:0] start_limit;
  logic ovf_flag_q;
  logic per_flag_q;
  logic ovf_ie_q;
  logic per_ie_q;
  logic [1:0] sel_q;
  logic protect_q;
  logic opt_q;
  logic [CTW_WD_W-1:0] wd_q;
  logic wd_req_q;
  logic wr_pend_q;
  logic [3:0] wr_addr_q;
  logic rd_addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  logic bus_take;
  logic wr_ctrl;
  logic wr_wdog;
  logic per_edge;
  logic ovf_edge;
  logic wd_run;
  logic wd_clear;
  logic wd_timeout;
  logic per_src;

  // Periodic source tap for 2^15..2^18 oscillator cycles, i.e. chain bit 11..14
  function automatic logic per_tap(input logic [CTW_CHAIN_W-1:0] c, input logic [1:0] s);
    per_tap = c[4'd11 + {2'b00, s}];
  endfunction

  // Chain rollover of a tap on the next tick
  function automatic logic roll(input logic [CTW_CHAIN_W-1:0] c, input logic [3:0] b);
    logic [CTW_CHAIN_W-1:0] m;
    m = (15'h1 << b) - 15'h1;
    roll = ((c & m) == m);
  endfunction

  // Startup delay: the chain runs, then is cleared again on release
  assign start_limit = options.long_delay ? DELAY_LONG_C : CTW_DELAY_SHORT_C;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_cnt_q <= 13'h0;
      startup_q <= 1'b1;
    end else if (clk_en && startup_q) begin
      start_cnt_q <= start_cnt_q + 13'h1;
      if (start_cnt_q == start_limit - 13'h1) begin
        startup_q <= 1'b0;
      end
    end
  end

  assign chain_clear = startup_q && (start_cnt_q == start_limit - 13'h1);
  assign in_startup = startup_q;

  ctw_chain u_chain (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .clear(chain_clear),
    .chain_q(chain),
    .tick(tick)
  );

  // Events: the low eight stages wrap, and the selected tap wraps
  assign ovf_edge = tick && roll(chain, 4'd8) && !startup_q;
  assign per_src = per_tap(chain, sel_q);
  // The tap falls when it and every stage below it wrap, hence one stage past the tap
  assign per_edge = tick && roll(chain, 4'd12 + {2'b00, sel_q}) && !startup_q;

  // AHB-Lite: zero wait states; writes land at the data phase
  assign bus_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = wr_pend_q && (wr_addr_q == CTW_ADDR_CTRL);
  assign wr_wdog = wr_pend_q && (wr_addr_q == CTW_ADDR_WDOG);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
    end else if (clk_en) begin
      wr_pend_q <= bus_take && hwrite;
      wr_addr_q <= haddr[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_ie_q <= 1'b0;
      per_ie_q <= 1'b0;
      sel_q <= CTW_SEL_RESET;
      protect_q <= 1'b0;
      opt_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ovf_ie_q <= hwdata[CTW_B_OVF_IE];
        per_ie_q <= hwdata[CTW_B_PER_IE];
        sel_q <= hwdata[CTW_B_SEL_HI:CTW_B_SEL_LO];
      end
      if (wr_wdog) begin
        // Sticky until reset, so code cannot unprotect itself
        protect_q <= protect_q | hwdata[CTW_B_PROTECT];
        opt_q <= hwdata[CTW_B_OPTFEAT];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag_q <= 1'b0;
      per_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (ovf_edge) begin
        ovf_flag_q <= 1'b1;
      end else if (wr_ctrl && hwdata[CTW_B_OVF_CLR]) begin
        ovf_flag_q <= 1'b0;
      end
      if (per_edge) begin
        per_flag_q <= 1'b1;
      end else if (wr_ctrl && hwdata[CTW_B_PER_CLR]) begin
        per_flag_q <= 1'b0;
      end
    end
  end

  assign overflow_irq = ovf_flag_q && ovf_ie_q;
  assign periodic_irq = per_flag_q && per_ie_q;

  // Watchdog: four stages clocked by the periodic tap
  assign wd_run = options.wd_enable && !prog_voltage_high && !startup_q
    && !(mode.stop_mode && !options.stop_to_halt);
  assign wd_clear = !wd_run || wd_req_q || (wr_wdog && !hwdata[CTW_B_WD_CLR]);
  // Clear lands mid-period, so the 8th edge comes 7 to 8 periods later
  assign wd_timeout = wd_run && per_edge && (wd_q == CTW_WD_TIMEOUT) && !wd_clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_q <= 4'h0;
      wd_req_q <= 1'b0;
    end else if (clk_en) begin
      wd_req_q <= wd_timeout;
      if (wd_clear) begin
        wd_q <= 4'h0;
      end else if (per_edge) begin
        wd_q <= wd_q + 4'h1;
      end
    end
  end

  assign system_reset_req = wd_req_q;
  assign program_memory_protect = protect_q;
  assign optional_features_enable = opt_q;

  // Read data registered at the address phase
  assign rd_addr_ok = (haddr[3:0] == CTW_ADDR_CTRL) || (haddr[3:0] == CTW_ADDR_COUNT)
    || (haddr[3:0] == CTW_ADDR_WDOG);
  always_comb begin
    rd_mux = 32'h0;
    case (haddr[3:0])
      CTW_ADDR_CTRL: begin
        rd_mux[CTW_B_OVF_FLAG] = ovf_flag_q;
        rd_mux[CTW_B_PER_FLAG] = per_flag_q;
        rd_mux[CTW_B_OVF_IE] = ovf_ie_q;
        rd_mux[CTW_B_PER_IE] = per_ie_q;
        rd_mux[CTW_B_SEL_HI:CTW_B_SEL_LO] = sel_q;
      end
      CTW_ADDR_COUNT: begin
        rd_mux[7:0] = chain[7:0];
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0;
    end else if (clk_en && bus_take && !hwrite) begin
      rdata_q <= rd_addr_ok ? rd_mux : 32'h0;
    end
  end

  assign hrdata = rdata_q;

  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:4], per_src, mode.wait_mode, mode.halt_mode};

  // Checks: prescaler and chain
  // The startup clear restarts the prescaler, so a cleared cycle voids the period check
  AST_PRESCALE: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && tick) ##1 ((clk_en && !chain_clear) [*4]) |-> tick)
    else $error("prescale period wrong");
  AST_CHAIN_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && tick) |=> chain == $past(chain) + 15'h1)
    else $error("chain did not step");
  AST_CHAIN_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !tick && !chain_clear) |=> chain == $past(chain))
    else $error("chain moved between ticks");
  AST_CHAIN_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && chain_clear) |=> chain == 15'h0)
    else $error("chain not cleared at startup end");
  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
    !clk_en |=> chain == $past(chain) && sel_q == $past(sel_q) && wd_q == $past(wd_q)
      && ovf_flag_q == $past(ovf_flag_q) && per_flag_q == $past(per_flag_q))
    else $error("state moved without clock enable");

  // Checks: control register and flags
  AST_SEL_RESET: assert property (@(posedge hclk) $rose(hresetn) |-> sel_q == 2'h3)
    else $error("rate select not reset high");
  AST_SEL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_ctrl) |=> sel_q == $past(hwdata[CTW_B_SEL_HI:CTW_B_SEL_LO]))
    else $error("rate select not written");
  AST_OVF_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_edge) |=> ovf_flag_q) else $error("overflow flag not set");
  AST_OVF_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_edge) |=> chain[7:0] == 8'h00)
    else $error("overflow not at low stage wrap");
  AST_PER_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && per_edge) |=> per_flag_q) else $error("periodic flag not set");
  AST_PER_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && per_edge) |=> chain[11:0] == 12'h000)
    else $error("periodic event before its tap wraps");
  AST_FLAG_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_ctrl && hwdata[CTW_B_OVF_CLR] && !ovf_edge) |=> !ovf_flag_q)
    else $error("overflow flag not cleared");
  AST_PER_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_ctrl && hwdata[CTW_B_PER_CLR] && !per_edge) |=> !per_flag_q)
    else $error("periodic flag not cleared");
  AST_RD_CLR_BITS: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && bus_take && !hwrite && haddr[3:0] == CTW_ADDR_CTRL)
      |=> !hrdata[CTW_B_OVF_CLR] && !hrdata[CTW_B_PER_CLR])
    else $error("flag clear bits read back set");

  // Checks: watchdog
  AST_WD_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_wdog && !hwdata[CTW_B_WD_CLR]) |=> wd_q == 4'h0 && !system_reset_req)
    else $error("watchdog not cleared");
  AST_WD_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && (prog_voltage_high || !options.wd_enable)) |=> wd_q == 4'h0)
    else $error("watchdog runs while off");
  AST_WD_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && per_edge && !wd_clear) |=> wd_q == $past(wd_q) + 4'h1)
    else $error("watchdog did not step on periodic event");
  AST_WD_REQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wd_timeout) |=> system_reset_req)
    else $error("timeout without reset request");
  AST_WD_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !options.wd_enable) |=> !system_reset_req)
    else $error("reset request with watchdog disabled");
  AST_WD_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    system_reset_req && clk_en |=> !system_reset_req && wd_q == 4'h0)
    else $error("reset request not single");
  AST_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && mode.stop_mode && !options.stop_to_halt) |=> wd_q == 4'h0)
    else $error("watchdog runs in stop");

  // Checks: security, options and read-back
  AST_PROTECT: assert property (@(posedge hclk) disable iff (!hresetn)
    protect_q |=> protect_q)
    else $error("protection dropped");
  AST_OPT_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_wdog) |=> optional_features_enable == $past(hwdata[CTW_B_OPTFEAT]))
    else $error("optional features bit not written");
  AST_COUNT_RD: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && bus_take && !hwrite && haddr[3:0] == CTW_ADDR_COUNT) |=> hrdata[31:8] == 24'h0)
    else $error("count read high bits");
  AST_WDOG_RD: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && bus_take && !hwrite && haddr[3:0] == CTW_ADDR_WDOG) |=> hrdata == 32'h0)
    else $error("write-only register read back nonzero");

  COV_TIMEOUT: cover property (@(posedge hclk) disable iff (!hresetn) system_reset_req);
  COV_OVF: cover property (@(posedge hclk) disable iff (!hresetn) overflow_irq);
  COV_PER: cover property (@(posedge hclk) disable iff (!hresetn) periodic_irq);
  COV_WD_CLEARED: cover property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_wdog && !hwdata[CTW_B_WD_CLR] && wd_q != 4'h0);
  COV_STARTUP_END: cover property (@(posedge hclk) disable iff (!hresetn) $fell(startup_q));
endmodule

/* test/core_timer_rti_watchdog_tb.sv */
`timescale 1ns/10ps
module core_timer_rti_watchdog_tb;
  import ctw_pkg::*;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] m;
  } ctw_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic prog_voltage_high = 1'b0;
  ctw_mode_t mode = '0;
  ctw_option_t options = '0;
  logic hsel, hwrite, hreadyout, hresp, stuck, prot, optf;
  logic overflow_irq, periodic_irq, system_reset_req, in_startup;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] r, c0;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int t1, n;
  wire logic [2:0] watch = {~in_startup, periodic_irq, overflow_irq};
  // Last write leaves rate select at 00 for the timing scenarios
  ctw_row_t rows [11] = '{
    '{1'b0, CTW_ADDR_CTRL, 8'h03, 8'h3f}, '{1'b1, CTW_ADDR_CTRL, 8'h3d, 8'h00},
    '{1'b0, CTW_ADDR_CTRL, 8'h31, 8'h3f}, '{1'b1, CTW_ADDR_CTRL, 8'h12, 8'h00},
    '{1'b0, CTW_ADDR_CTRL, 8'h12, 8'h3f}, '{1'b1, CTW_ADDR_CTRL, 8'h23, 8'h00},
    '{1'b0, CTW_ADDR_CTRL, 8'h23, 8'h3f}, '{1'b1, CTW_ADDR_CTRL, 8'h3c, 8'h00},
    '{1'b0, CTW_ADDR_CTRL, 8'h30, 8'h3f}, '{1'b0, CTW_ADDR_WDOG, 8'h00, 8'hff},
    '{1'b0, 4'hc, 8'h00, 8'hff}};

  ctw_top #(.DELAY_LONG(40)) dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mode(mode), .options(options), .prog_voltage_high(prog_voltage_high),
    .overflow_irq(overflow_irq), .periodic_irq(periodic_irq),
    .system_reset_req(system_reset_req), .in_startup(in_startup),
    .program_memory_protect(prot), .optional_features_enable(optf));
  ctw_cpu_model cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .stuck(stuck));

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Sampled 1 ns after the edge so the design's updates have landed
  task automatic wait_hi(input int b, input int lim);
    n = 0;
    while (watch[b] !== 1'b1) begin
      if (n == lim) begin
        num_errors++;
        $display("wrong value at %0t: timeout", $time);
        tally_and_finish();
      end
      n++;
      @(posedge hclk);
      #1;
    end
  endtask
  task automatic startup(input int exp);
    hresetn <= 1'b1;
    t1 = cyc;
    wait_hi(2, 5000);
    check(8'(cyc - t1 >= exp && cyc - t1 <= exp + 2), 8'h01, "startup length");
    cpu.xfer(1'b0, CTW_ADDR_COUNT, 8'h00, r);
    check(8'(r < 8'h02), 8'h01, "count cleared after startup");
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    check({7'h0, in_startup}, 8'h01, "startup during reset");
    startup(16);
    foreach (rows[i]) begin
      if (rows[i].wr && rows[i].a == CTW_ADDR_CTRL)
        cpu.xfer(1'b1, CTW_ADDR_WDOG, 8'h00, r);
      cpu.xfer(rows[i].wr, rows[i].a, rows[i].d, r);
      if (!rows[i].wr) check(r & rows[i].m, rows[i].d, "register");
    end
    // A count write between the reads must not disturb the chain
    cpu.xfer(1'b0, CTW_ADDR_COUNT, 8'h00, c0);
    cpu.xfer(1'b1, CTW_ADDR_COUNT, 8'h55, r);
    repeat (36) @(posedge hclk);
    cpu.xfer(1'b0, CTW_ADDR_COUNT, 8'h00, r);
    check(r - c0, 8'd10, "count rate");
    // The two enable-high edges after the first read may add one tick; with the enable low the chain holds
    cpu.xfer(1'b0, CTW_ADDR_COUNT, 8'h00, c0);
    clk_en <= 1'b0;
    repeat (36) @(posedge hclk);
    clk_en <= 1'b1;
    cpu.xfer(1'b0, CTW_ADDR_COUNT, 8'h00, r);
    check(8'(r - c0 <= 8'h01), 8'h01, "count frozen without enable");
    cpu.xfer(1'b1, CTW_ADDR_CTRL, 8'h3c, r);
    wait_hi(0, 1100);
    t1 = cyc;
    cpu.xfer(1'b1, CTW_ADDR_CTRL, 8'h38, r);
    #1;
    check({7'h0, overflow_irq}, 8'h00, "overflow clear");
    wait_hi(0, 1100);
    check(8'(cyc - t1 == 1024), 8'h01, "overflow period");
    // Watchdog on from here; it steps once per periodic event
    options.wd_enable <= 1'b1;
    cpu.xfer(1'b1, CTW_ADDR_WDOG, 8'h00, r);
    mode.wait_mode <= 1'b1;
    mode.halt_mode <= 1'b1;
    #1;
    wait_hi(1, 17000);
    t1 = cyc;
    cpu.xfer(1'b1, CTW_ADDR_CTRL, 8'h34, r);
    #1;
    check({7'h0, periodic_irq}, 8'h00, "periodic clear");
    wait_hi(1, 17000);
    check(8'(cyc - t1 == 16384), 8'h01, "periodic period");
    check({4'h0, dut.wd_q}, 8'h02, "watchdog steps in wait and halt");
    options.stop_to_halt <= 1'b1;
    mode.stop_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    check({4'h0, dut.wd_q}, 8'h02, "watchdog kept in stop as halt");
    options.stop_to_halt <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    check({4'h0, dut.wd_q}, 8'h00, "stop clears watchdog");
    mode <= '0;
    cpu.xfer(1'b1, CTW_ADDR_CTRL, 8'h34, r);
    #1;
    wait_hi(1, 17000);
    check({4'h0, dut.wd_q}, 8'h01, "watchdog runs again after stop");
    cpu.xfer(1'b1, CTW_ADDR_WDOG, 8'h07, r);
    #1;
    check({6'h0, prot, optf}, 8'h03, "protect and features set");
    check({4'h0, dut.wd_q}, 8'h01, "clear bit 1 leaves watchdog");
    cpu.xfer(1'b1, CTW_ADDR_WDOG, 8'h00, r);
    #1;
    check({6'h0, prot, optf}, 8'h02, "protect stays set");
    check({4'h0, dut.wd_q}, 8'h00, "clear bit 0 clears watchdog");
    check({7'h0, system_reset_req}, 8'h00, "no watchdog reset");
    check({6'h0, stuck, hresp}, 8'h00, "bus answers");
    // Second reset in mid-run, this time with the long startup option
    hresetn <= 1'b0;
    options.long_delay <= 1'b1;
    @(posedge hclk);
    #1;
    check({5'h0, in_startup, prot, system_reset_req}, 8'h04, "values in reset");
    @(posedge hclk);
    startup(40);
    tally_and_finish();
  end
endmodule

/* test/ctw_cpu_model.sv */
`timescale 1ns/10ps
// Bus master standing in for the CPU core; single word transfers only
module ctw_cpu_model (
  // Bus
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Raised when the slave never answered
  output logic stuck
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stuck = 1'b0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    if (n == 64) stuck = 1'b1;
  endtask
  // Call just after a rising edge; read data comes back in r
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    r = hrdata[7:0];
    // Stale write data must not look valid after the data phase
    hwdata <= ~{24'h0, d};
  endtask
endmodule
